// ===== verilog/isc_params.svh
`ifndef ISC_PARAMS_SVH
`define ISC_PARAMS_SVH

// ----------------------------------------------------------------------
// clock and channel count
// ----------------------------------------------------------------------
`define ISC_CLK_PERIOD_NS 5
`define ISC_NUM_CH 4

// ----------------------------------------------------------------------
// barrier timing: times as printed, cycle counts derived from the clock
// ----------------------------------------------------------------------
`define ISC_PULSE_NS 1
`define ISC_PULSE_CYC ((`ISC_PULSE_NS + `ISC_CLK_PERIOD_NS - 1) / `ISC_CLK_PERIOD_NS)
`define ISC_REFRESH_US 1
`define ISC_REFRESH_CYC ((`ISC_REFRESH_US * 1000) / `ISC_CLK_PERIOD_NS)
`define ISC_WDOG_US 5
`define ISC_WDOG_CYC ((`ISC_WDOG_US * 1000) / `ISC_CLK_PERIOD_NS)
`define ISC_REF_W 8
`define ISC_WD_W 10

// ----------------------------------------------------------------------
// converter timing and limits
// ----------------------------------------------------------------------
`define ISC_HICCUP_MS 2
`define ISC_HICCUP_CYC ((`ISC_HICCUP_MS * 1000000) / `ISC_CLK_PERIOD_NS)
`define ISC_HIC_W 19
`define ISC_PWM_PERIOD_NS 1000
`define ISC_PWM_CYC (`ISC_PWM_PERIOD_NS / `ISC_CLK_PERIOD_NS)
`define ISC_PWM_W 8
`define ISC_DUTY_MAX 8'h5A
`define ISC_ILIM_MA 1200

// ----------------------------------------------------------------------
// channel layout: set bit = reverse channel, plus watchdog defaults
// ----------------------------------------------------------------------
`define ISC_CH_DIR 4'h8
`define ISC_WDOG_DFLT 4'h0

`endif

// ===== verilog/isc_pkg.sv
package isc_pkg;

  // ----------------------------------------------------------------------
  // pulse pair crossing the barrier
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic set;
    logic rst;
  } isc_pulse_t;

  // external sense levels, all asynchronous to i_clk
  typedef struct packed {
    logic pri_ok;
    logic sec_ok;
    logic vout_ok;
    logic short_det;
    logic ilim;
    logic sec_pwm;
  } isc_sense_t;

  // push-pull gate drive
  typedef struct packed {
    logic sw_a;
    logic sw_b;
  } isc_drive_t;

  // converter modes
  typedef enum logic [1:0] {
    ISC_OFF,
    ISC_SOFT,
    ISC_NORMAL,
    ISC_HICCUP
  } isc_conv_state_t;

endpackage : isc_pkg

// ===== verilog/isc_channel.sv
`timescale 1ns/1ps
`include "isc_params.svh"

module isc_channel
  import isc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tx_en,
  input wire logic i_rx_en,
  input wire logic i_din,
  input wire logic i_wdog_dflt,
  output logic o_dout,
  output isc_pulse_t o_pulse
);

  localparam logic [`ISC_REF_W-1:0] REF_LAST =
    `ISC_REF_W'(`ISC_REFRESH_CYC - 1);
  localparam logic [`ISC_WD_W-1:0] WD_LAST = `ISC_WD_W'(`ISC_WDOG_CYC - 1);

  function automatic isc_pulse_t level_pulse(input logic lvl);
    isc_pulse_t p;
    p.set = lvl;
    p.rst = !lvl;
    return p;
  endfunction : level_pulse

  // ----------------------------------------------------------------------
  // encoder: one-cycle pulse per edge, start-up sample, periodic refresh
  // ----------------------------------------------------------------------
  logic tx_live_r, tx_live_nxt;
  logic last_r, last_nxt;
  logic [`ISC_REF_W-1:0] ref_cnt_r, ref_cnt_nxt;
  isc_pulse_t pulse_r, pulse_nxt;

  // a pulse of one cycle (5 ns) is the shortest the clock can carry
  always_comb begin
    tx_live_nxt = i_tx_en;
    last_nxt = 1'b0;
    ref_cnt_nxt = '0;
    pulse_nxt = '0;
    if (i_tx_en) begin
      last_nxt = i_din;
      if (!tx_live_r || i_din != last_r || ref_cnt_r == REF_LAST) begin
        pulse_nxt = level_pulse(i_din);
      end else begin
        ref_cnt_nxt = ref_cnt_r + `ISC_REF_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_live_r <= 1'b0;
      last_r <= 1'b0;
      ref_cnt_r <= '0;
      pulse_r <= '0;
    end else begin
      tx_live_r <= tx_live_nxt;
      last_r <= last_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // decoder: bistable latch with a no-pulse watchdog
  // ----------------------------------------------------------------------
  logic dout_r, dout_nxt;
  logic [`ISC_WD_W-1:0] wd_cnt_r, wd_cnt_nxt;

  // unpowered receiver reads low; watchdog count saturates once it trips
  always_comb begin
    dout_nxt = 1'b0;
    wd_cnt_nxt = '0;
    if (i_rx_en) begin
      dout_nxt = dout_r;
      if (pulse_r.set) begin
        dout_nxt = 1'b1;
      end else if (pulse_r.rst) begin
        dout_nxt = 1'b0;
      end else if (wd_cnt_r == WD_LAST) begin
        dout_nxt = i_wdog_dflt;
        wd_cnt_nxt = wd_cnt_r;
      end else begin
        wd_cnt_nxt = wd_cnt_r + `ISC_WD_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dout_r <= 1'b0;
      wd_cnt_r <= '0;
    end else begin
      dout_r <= dout_nxt;
      wd_cnt_r <= wd_cnt_nxt;
    end
  end

  assign o_dout = dout_r;
  assign o_pulse = pulse_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_EDGE_PULSE: assert property (
    (i_tx_en && tx_live_r && i_din != last_r) |=>
      (pulse_r.set == $past(i_din) && pulse_r.rst == !$past(i_din)))
    else $error("edge at input sent no matching pulse");
  AST_DECODE: assert property (
    (i_rx_en && pulse_r.set) |=> o_dout)
    else $error("set pulse did not set output");
  AST_DECODE_RST: assert property (
    (i_rx_en && pulse_r.rst && !pulse_r.set) ##1 i_rx_en |-> !o_dout)
    else $error("reset pulse did not clear output");
  AST_REFRESH: assert property (
    (i_tx_en && tx_live_r && ref_cnt_r == REF_LAST) |=>
      (pulse_r.set || pulse_r.rst))
    else $error("idle input sent no refresh pulse");
  AST_WDOG: assert property (
    (i_rx_en && wd_cnt_r == WD_LAST && !pulse_r.set && !pulse_r.rst)
      ##1 i_rx_en |-> o_dout == i_wdog_dflt)
    else $error("watchdog did not force default");
  AST_TX_IDLE: assert property (
    !i_tx_en |=> !pulse_r.set && !pulse_r.rst)
    else $error("unpowered encoder sent a pulse");
  AST_RX_LOW: assert property (!i_rx_en |=> !o_dout)
    else $error("unpowered decoder output not low");
  AST_START: assert property (
    (i_tx_en && !tx_live_r) |=> (pulse_r.set || pulse_r.rst))
    else $error("no sample pulse on power-up");
  AST_REF_LT_WD: assert property (
    (tx_live_r && $past(tx_live_r)) |-> wd_cnt_r != WD_LAST)
    else $error("watchdog reached its limit while input powered");
  AST_TRACK: assert property (
    ($rose(i_rx_en) && tx_live_r) |-> ##[1:202]
      (o_dout == i_din || !i_rx_en || !i_tx_en))
    else $error("output not valid within 1 us of init");

  COV_REFRESH: cover property (i_tx_en && tx_live_r && ref_cnt_r == REF_LAST);
  COV_WDOG: cover property (i_rx_en && wd_cnt_r == WD_LAST);

endmodule : isc_channel

// ===== verilog/isc_top.sv
`timescale 1ns/1ps
`include "isc_params.svh"

// Behaviour
// - one short pulse per input edge
// - decoder set and reset by pulses
// - refresh pulses after one microsecond idle
// - watchdog forces default after five microseconds
// - first power-up starts in soft start
// - above threshold, secondary PWM takes control
// - short: stop two milliseconds, then soft start
// - short still present: repeat hiccup cycle
// - short gone after restart: normal operation
// - current limit ends each switching pulse
// - below lockout: idle, oscillator off, outputs low
// - primary outputs low until pulses arrive
// - primary inputs sampled and sent at start
// - secondary outputs low until pulse arrives
// - secondary output valid within one microsecond
// - secondary inputs sampled and sent at start
// - outputs hold until lockout or watchdog

module isc_top
  import isc_pkg::*;
#(
  parameter logic [`ISC_HIC_W-1:0] HICCUP_CYCLES =
    `ISC_HIC_W'(`ISC_HICCUP_CYC)
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_primary_supply_ok,
  input wire logic i_secondary_supply_ok,
  input wire logic i_vout_above_thr,
  input wire logic i_short_det,
  input wire logic i_ilim,
  input wire logic i_sec_pwm,
  input wire logic [`ISC_NUM_CH-1:0] i_pri_in,
  input wire logic [`ISC_NUM_CH-1:0] i_sec_in,
  output logic [`ISC_NUM_CH-1:0] o_pri_out,
  output logic [`ISC_NUM_CH-1:0] o_sec_out,
  output logic o_primary_switch_a,
  output logic o_primary_switch_b,
  output logic o_osc_en,
  output isc_conv_state_t o_conv_state
);

  // last values of the PWM and hiccup counters; PWM wraps back to zero, hiccup holds at its last value
  localparam logic [`ISC_PWM_W-1:0] PWM_LAST =
    `ISC_PWM_W'(`ISC_PWM_CYC - 1);
  localparam logic [`ISC_HIC_W-1:0] HIC_LAST =
    HICCUP_CYCLES - `ISC_HIC_W'(1);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  isc_sense_t sense_s1_r, sense_s2_r;
  logic [`ISC_NUM_CH-1:0] pri_s1_r, pri_s2_r;
  logic [`ISC_NUM_CH-1:0] sec_s1_r, sec_s2_r;

  // every pin is asynchronous; first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sense_s1_r <= '0;
      sense_s2_r <= '0;
      pri_s1_r <= '0;
      pri_s2_r <= '0;
      sec_s1_r <= '0;
      sec_s2_r <= '0;
    end else begin
      sense_s1_r <= '{i_primary_supply_ok, i_secondary_supply_ok,
                      i_vout_above_thr, i_short_det, i_ilim, i_sec_pwm};
      sense_s2_r <= sense_s1_r;
      pri_s1_r <= i_pri_in;
      pri_s2_r <= pri_s1_r;
      sec_s1_r <= i_sec_in;
      sec_s2_r <= sec_s1_r;
    end
  end

  logic pri_ok, sec_ok;
  assign pri_ok = sense_s2_r.pri_ok;
  assign sec_ok = sense_s2_r.sec_ok;

  // ----------------------------------------------------------------------
  // data channels
  // ----------------------------------------------------------------------
  localparam logic [`ISC_NUM_CH-1:0] CH_DIR = `ISC_CH_DIR;
  localparam logic [`ISC_NUM_CH-1:0] CH_DFLT = `ISC_WDOG_DFLT;
  logic [`ISC_NUM_CH-1:0] ch_dout;

  // each channel's encoder sits on its input side, decoder on the other
  for (genvar g = 0; g < `ISC_NUM_CH; g++) begin : g_ch
    isc_channel u_ch (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_tx_en(CH_DIR[g] ? sec_ok : pri_ok),
      .i_rx_en(CH_DIR[g] ? pri_ok : sec_ok),
      .i_din(CH_DIR[g] ? sec_s2_r[g] : pri_s2_r[g]),
      .i_wdog_dflt(CH_DFLT[g]),
      .o_dout(ch_dout[g]),
      .o_pulse()
    );
    // unused direction reads low so no undefined state leaks out
    assign o_pri_out[g] = CH_DIR[g] ? ch_dout[g] : 1'b0;
    assign o_sec_out[g] = CH_DIR[g] ? 1'b0 : ch_dout[g];
  end

  // ----------------------------------------------------------------------
  // converter state machine and push-pull PWM
  // ----------------------------------------------------------------------
  isc_conv_state_t state_r, state_nxt;
  logic [`ISC_PWM_W-1:0] duty_r, duty_nxt;
  logic [`ISC_PWM_W-1:0] pwm_cnt_r, pwm_cnt_nxt;
  logic phase_r, phase_nxt;
  logic [`ISC_HIC_W-1:0] hic_cnt_r, hic_cnt_nxt;
  logic ilim_hit_r, ilim_hit_nxt;
  isc_drive_t drive_r, drive_nxt;
  logic pwm_wrap;
  logic soft_end;
  logic drive_on;

  assign pwm_wrap = (pwm_cnt_r == PWM_LAST);
  assign soft_end = sense_s2_r.vout_ok || (duty_r == `ISC_DUTY_MAX);

  // soft start ignores a short until its ramp ends, so a hard short
  // costs one full ramp plus the off time per hiccup round
  always_comb begin
    state_nxt = state_r;
    duty_nxt = duty_r;
    hic_cnt_nxt = hic_cnt_r;
    pwm_cnt_nxt = pwm_wrap ? '0 : pwm_cnt_r + `ISC_PWM_W'(1);
    phase_nxt = pwm_wrap ? !phase_r : phase_r;
    case (state_r)
      ISC_OFF: begin
        state_nxt = ISC_SOFT;
        duty_nxt = '0;
        pwm_cnt_nxt = '0;
        phase_nxt = 1'b0;
      end
      ISC_SOFT: begin
        if (pwm_wrap && duty_r != `ISC_DUTY_MAX) begin
          duty_nxt = duty_r + `ISC_PWM_W'(1);
        end
        if (soft_end && sense_s2_r.short_det) begin
          state_nxt = ISC_HICCUP;
          hic_cnt_nxt = '0;
        end else if (sense_s2_r.vout_ok) begin
          state_nxt = ISC_NORMAL;
        end
      end
      ISC_NORMAL: begin
        if (sense_s2_r.short_det) begin
          state_nxt = ISC_HICCUP;
          hic_cnt_nxt = '0;
        end
      end
      ISC_HICCUP: begin
        if (hic_cnt_r == HIC_LAST) begin
          state_nxt = ISC_SOFT;
          duty_nxt = '0;
        end else begin
          hic_cnt_nxt = hic_cnt_r + `ISC_HIC_W'(1);
        end
      end
      default: begin
        state_nxt = ISC_OFF;
      end
    endcase
    // lockout overrides everything and parks the oscillator
    if (!pri_ok) begin
      state_nxt = ISC_OFF;
      duty_nxt = '0;
      pwm_cnt_nxt = '0;
      phase_nxt = 1'b0;
      hic_cnt_nxt = '0;
    end
  end

  // current limit blocks the rest of the period; cleared at its start
  always_comb begin
    ilim_hit_nxt = (pwm_wrap ? 1'b0 : ilim_hit_r) | sense_s2_r.ilim;
    drive_on = 1'b0;
    if (state_nxt == ISC_SOFT) begin
      drive_on = (pwm_cnt_nxt < duty_nxt);
    end else if (state_nxt == ISC_NORMAL) begin
      drive_on = sense_s2_r.sec_pwm && (pwm_cnt_nxt < `ISC_DUTY_MAX);
    end
    drive_on = drive_on && !ilim_hit_nxt;
    drive_nxt.sw_a = drive_on && !phase_nxt;
    drive_nxt.sw_b = drive_on && phase_nxt;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= ISC_OFF;
      duty_r <= '0;
      pwm_cnt_r <= '0;
      phase_r <= 1'b0;
      hic_cnt_r <= '0;
      ilim_hit_r <= 1'b0;
      drive_r <= '0;
    end else begin
      state_r <= state_nxt;
      duty_r <= duty_nxt;
      pwm_cnt_r <= pwm_cnt_nxt;
      phase_r <= phase_nxt;
      hic_cnt_r <= hic_cnt_nxt;
      ilim_hit_r <= ilim_hit_nxt;
      drive_r <= drive_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign o_primary_switch_a = drive_r.sw_a;
  assign o_primary_switch_b = drive_r.sw_b;
  assign o_osc_en = (state_r != ISC_OFF);
  assign o_conv_state = state_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // all checks share the core clock and stay quiet while reset is held
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_SOFT_FIRST: assert property (
    (state_r == ISC_OFF && pri_ok) |=> state_r == ISC_SOFT && duty_r == '0)
    else $error("power-up did not enter soft start");
  AST_SOFT_RAMP: assert property (
    (state_r == ISC_SOFT && state_nxt == ISC_SOFT && pwm_wrap &&
     duty_r != `ISC_DUTY_MAX) |=> duty_r == $past(duty_r) + `ISC_PWM_W'(1))
    else $error("soft start duty did not widen");
  AST_HANDOVER: assert property (
    (state_r == ISC_SOFT && pri_ok && sense_s2_r.vout_ok &&
     !sense_s2_r.short_det) |=> state_r == ISC_NORMAL)
    else $error("no handover to normal regulation");
  AST_SHORT_STOP: assert property (
    (state_r == ISC_NORMAL && pri_ok && sense_s2_r.short_det) |=>
      state_r == ISC_HICCUP ##1 (!drive_r.sw_a && !drive_r.sw_b))
    else $error("short did not stop switching");
  AST_HICCUP_QUIET: assert property (
    (state_r == ISC_HICCUP) |-> !drive_r.sw_a && !drive_r.sw_b)
    else $error("switching during hiccup off time");
  AST_HICCUP_HOLD: assert property (
    (state_r == ISC_HICCUP && pri_ok && hic_cnt_r != HIC_LAST) |=>
      state_r == ISC_HICCUP &&
      hic_cnt_r == $past(hic_cnt_r) + `ISC_HIC_W'(1))
    else $error("hiccup off time cut short");
  AST_HICCUP_RESTART: assert property (
    (state_r == ISC_HICCUP && pri_ok && hic_cnt_r == HIC_LAST) |=>
      state_r == ISC_SOFT)
    else $error("hiccup did not restart soft start");
  AST_HICCUP_REPEAT: assert property (
    (state_r == ISC_SOFT && pri_ok && soft_end && sense_s2_r.short_det)
      |=> state_r == ISC_HICCUP)
    else $error("persisting short did not repeat hiccup");
  AST_ILIM: assert property (
    (sense_s2_r.ilim && !pwm_wrap) |=> ##1
      (!drive_r.sw_a && !drive_r.sw_b) || $past(pwm_wrap))
    else $error("current limit did not end pulse");
  AST_LOCKOUT: assert property (
    !pri_ok |=> state_r == ISC_OFF && !drive_r.sw_a && !drive_r.sw_b)
    else $error("converter active below lockout");
  AST_PUSH_PULL: assert property (
    !(drive_r.sw_a && drive_r.sw_b))
    else $error("both switches driven together");

  // the checks below watch the gating terms one by one, so a broken
  // term shows up by name rather than as a vague drive mismatch
  AST_ILIM_PERIOD: assert property (
    (ilim_hit_r && !pwm_wrap) |=> !drive_r.sw_a && !drive_r.sw_b)
    else $error("latched current limit let a switch on");
  AST_SOFT_WIDTH: assert property (
    (state_nxt == ISC_SOFT && pwm_cnt_nxt >= duty_nxt) |=>
      !drive_r.sw_a && !drive_r.sw_b)
    else $error("soft start pulse wider than its duty");
  AST_DUTY_CAP: assert property (
    duty_r <= `ISC_DUTY_MAX)
    else $error("soft start duty above its ceiling");
  AST_NORMAL_GATE: assert property (
    (state_nxt == ISC_NORMAL && !sense_s2_r.sec_pwm) |=>
      !drive_r.sw_a && !drive_r.sw_b)
    else $error("switch on without a secondary request");
  AST_HICCUP_ENTRY: assert property (
    (state_r == ISC_HICCUP && $past(state_r) != ISC_HICCUP) |->
      hic_cnt_r == '0)
    else $error("hiccup off time did not start from zero");
  AST_OSC_LOCKOUT: assert property (
    !pri_ok |=> !o_osc_en)
    else $error("oscillator running below lockout");

  COV_NORMAL: cover property (state_r == ISC_SOFT ##1 state_r == ISC_NORMAL);
  COV_HICCUP: cover property (state_r == ISC_NORMAL ##1 state_r == ISC_HICCUP);
  COV_ILIM: cover property (drive_r.sw_a ##1 !drive_r.sw_a && ilim_hit_r);

endmodule : isc_top

// ===== tb/isc_sec_model.sv
`timescale 1ns/1ps

module isc_sec_model
  import isc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pwr_en,
  input wire logic i_pwm_en,
  input wire isc_drive_t i_drive,
  output logic o_sec_ok,
  output logic o_vout_above,
  output logic o_sec_pwm
);
  // ----------------------------------------------------------------------
  // isolated output charge and secondary controller
  // ----------------------------------------------------------------------
  int charge;
  int tick;

  // each driven cycle charges the output cap, idle cycles leak slowly
  always @(negedge i_clk) begin
    if (!i_rst_n) begin
      charge <= 0;
      tick <= 0;
    end else begin
      tick <= (tick + 1) % 100;
      if (i_drive.sw_a || i_drive.sw_b)
        charge <= (charge < 400) ? charge + 1 : charge;
      else if (tick % 16 == 0 && charge > 0)
        charge <= charge - 1;
    end
  end

  // secondary supply follows the bench; threshold has no hysteresis
  assign o_sec_ok = i_pwr_en;
  assign o_vout_above = (charge >= 200);
  assign o_sec_pwm = i_pwm_en && (tick < 60);
endmodule : isc_sec_model

// ===== tb/test_isc_top.sv
`timescale 1ns/1ps
`include "isc_params.svh"
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("Error %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
`define WAITC(c, n) \
  begin \
    int k_; \
    for (k_ = 0; k_ < (n) && !(c); k_++) @(negedge clk); \
  end

module test_isc_top
  import isc_pkg::*;
;
  // ----------------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------------
  localparam int HIC = 50;
  logic clk, rst_n, pri_ok, sec_en, pwm_en, short_det, ilim;
  logic sec_ok, vout_ok, sec_pwm, sw_a, sw_b, osc_en;
  logic [`ISC_NUM_CH-1:0] pri_in, sec_in, o_pri_out, o_sec_out;
  isc_conv_state_t state;
  isc_drive_t drv;
  int fail_count, samples_checked;
  logic [31:0] seed;
  logic [7:0] hist[$];

  assign drv = '{sw_a: sw_a, sw_b: sw_b};

  // short hiccup keeps the run brief
  isc_top #(.HICCUP_CYCLES(`ISC_HIC_W'(HIC))) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_primary_supply_ok(pri_ok),
    .i_secondary_supply_ok(sec_ok), .i_vout_above_thr(vout_ok),
    .i_short_det(short_det), .i_ilim(ilim), .i_sec_pwm(sec_pwm),
    .i_pri_in(pri_in), .i_sec_in(sec_in), .o_pri_out(o_pri_out),
    .o_sec_out(o_sec_out), .o_primary_switch_a(sw_a),
    .o_primary_switch_b(sw_b), .o_osc_en(osc_en), .o_conv_state(state)
  );

  isc_sec_model i_sec (
    .i_clk(clk), .i_rst_n(rst_n), .i_pwr_en(sec_en), .i_pwm_en(pwm_en),
    .i_drive(drv), .o_sec_ok(sec_ok), .o_vout_above(vout_ok),
    .o_sec_pwm(sec_pwm)
  );

  // ----------------------------------------------------------------------
  // clock, helpers and model
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // channel model: output equals the input applied four cycles earlier
  task automatic step(input logic [3:0] pin, input logic [3:0] sin);
    logic [7:0] old;
    @(negedge clk);
    if (hist.size() >= 4) begin
      old = hist[hist.size() - 4];
      `CHK(o_sec_out, old[3:0] & ~`ISC_CH_DIR)
      `CHK(o_pri_out, old[7:4] & `ISC_CH_DIR)
    end
    pri_in = pin;
    sec_in = sin;
    hist.push_back({sin, pin});
    if (hist.size() > 8)
      void'(hist.pop_front());
  endtask : step

  // history restarts because inputs may have moved outside step
  task automatic run(input int n, input bit rnd);
    hist.delete();
    repeat (n) begin
      if (rnd)
        seed = xs(seed);
      step(rnd ? seed[3:0] : pri_in, rnd ? seed[7:4] : sec_in);
    end
  endtask : run

  task automatic sw_off(input int n);
    repeat (n) begin
      @(negedge clk);
      `CHK({sw_a, sw_b}, 2'h0)
    end
  endtask : sw_off

  // push-pull never shoots through; oscillator runs whenever not off
  always @(negedge clk) begin
    if (rst_n) begin
      `CHK(sw_a & sw_b, 1'b0)
      `CHK(osc_en, state != ISC_OFF)
    end
  end

  // hang guard sized well above the expected run
  initial begin
    repeat (60000) @(negedge clk);
    fail_count++;
    $display("Error %0t: timeout", $time);
    close_out();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n;
    fail_count = 0;
    samples_checked = 0;
    seed = 32'h0000002D;
    rst_n = 1'b0;
    pri_ok = 1'b0;
    sec_en = 1'b0;
    pwm_en = 1'b1;
    short_det = 1'b0;
    ilim = 1'b0;
    pri_in = 4'h5;
    sec_in = 4'h8;
    repeat (12) @(negedge clk);
    `CHK(state, ISC_OFF)
    `CHK({o_sec_out, o_pri_out}, 8'h00)
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    `CHK(state, ISC_OFF)
    pri_ok = 1'b1;
    `WAITC(state === ISC_SOFT, 6)
    `CHK(state, ISC_SOFT)
    sw_off(150);
    `CHK(o_pri_out, 4'h0)
    `CHK(o_sec_out, 4'h0)
    sec_en = 1'b1;
    `WAITC(o_sec_out === 4'h5, 220)
    `CHK(o_sec_out, 4'h5)
    `WAITC(o_pri_out === 4'h8, 220)
    `CHK(o_pri_out, 4'h8)
    `WAITC(state === ISC_NORMAL, 20000)
    `CHK(state, ISC_NORMAL)
    run(400, 1'b1);
    run(1500, 1'b0);
    ilim = 1'b1;
    repeat (4) @(negedge clk);
    sw_off(300);
    ilim = 1'b0;
    `WAITC((sw_a | sw_b) === 1'b1, 450)
    `CHK(sw_a | sw_b, 1'b1)
    pwm_en = 1'b0;
    repeat (5) @(negedge clk);
    sw_off(400);
    pwm_en = 1'b1;
    sec_en = 1'b0;
    repeat (6) @(negedge clk);
    `CHK(o_sec_out, 4'h0)
    sec_en = 1'b1;
    `WAITC(o_sec_out === (pri_in & ~`ISC_CH_DIR), 220)
    `CHK(o_sec_out, pri_in & ~`ISC_CH_DIR)
    short_det = 1'b1;
    `WAITC(state === ISC_HICCUP, 6)
    `CHK(state, ISC_HICCUP)
    n = 0;
    while (state === ISC_HICCUP && n < 200) begin
      @(negedge clk);
      n++;
    end
    `CHK(n == HIC || n == HIC + 1, 1'b1)
    `CHK(state, ISC_SOFT)
    `WAITC(state === ISC_HICCUP, 300)
    `CHK(state, ISC_HICCUP)
    short_det = 1'b0;
    `WAITC(state === ISC_NORMAL, 400)
    `CHK(state, ISC_NORMAL)
    @(negedge clk);
    pri_in = 4'h7;
    run(10, 1'b0);
    pri_ok = 1'b0;
    `WAITC(state === ISC_OFF, 6)
    `CHK(state, ISC_OFF)
    sw_off(10);
    // last refresh may precede the loss by 201 cycles: check well inside
    repeat (590) @(negedge clk);
    `CHK(o_sec_out, 4'h7)
    `WAITC(o_sec_out === 4'h0, 600)
    `CHK(o_sec_out, `ISC_WDOG_DFLT & ~`ISC_CH_DIR)
    `CHK(o_pri_out, 4'h0)
    close_out();
  end
endmodule : test_isc_top
